// ---- core/energy_pkg.sv ----
`default_nettype none
package energy_pkg;

	// register port
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam logic [5:0] ADDR_LINE_ACTIVE = 6'h04;
	localparam logic [5:0] ADDR_HALF_CYCLE = 6'h1C;
	localparam logic [5:0] ADDR_MODE = 6'h20;
	localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h21;
	localparam logic [5:0] ADDR_IRQ_STATUS = 6'h22;
	localparam logic [5:0] ADDR_LINE_REACTIVE = 6'h23;
	localparam logic [5:0] ADDR_APPARENT_GAIN = 6'h24;
	localparam logic [5:0] ADDR_APPARENT_POWER = 6'h25;
	localparam logic [5:0] ADDR_ACTIVE_POWER = 6'h26;
	localparam logic [5:0] ADDR_REACTIVE_POWER = 6'h27;
	localparam logic [5:0] ADDR_LINE_STATE = 6'h28;

	// field positions
	localparam int MODE_CYCLE_BIT = 7;
	localparam int MODE_POS_ONLY_BIT = 15;
	localparam int IRQ_CYCLE_END_BIT = 2;
	localparam int IRQ_WENT_NEG_BIT = 4;
	localparam int IRQ_WENT_POS_BIT = 5;

	// reset values
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
	localparam logic [15:0] HALF_CYCLE_RESET = 16'hFFFF;
	localparam logic [11:0] APPARENT_GAIN_RESET = 12'h000;

	// signal path
	localparam int LPF_SHIFT = 8;
	localparam int INTEG_SHIFT = 6;
	localparam int LINE_LSB = 16;
	localparam int GAIN_FRAC_BITS = 12;
	localparam longint POWER_FULL_SCALE = 64'h0000_0000_7FFF_FFFF;
	// threshold in thousandths of a percent of full scale
	localparam longint NO_LOAD_MILLI_PERCENT = 1;
	localparam longint NO_LOAD_THRESHOLD = POWER_FULL_SCALE * NO_LOAD_MILLI_PERCENT / 100000;
	localparam longint CF_ENERGY_STEP = 64'h0000_0001_0000_0000;

	// timing
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int CF_PULSE_NS = 1000;
	localparam int CF_PULSE_CYCLES = CF_PULSE_NS / CLOCK_PERIOD_NS;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [5:0] addr;
		logic [23:0] wrData;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic integratorOn;
		logic signed [15:0] voltage;
		logic signed [15:0] current;
	} sample_t;

	typedef struct packed {
		logic [15:0] voltageRms;
		logic [15:0] currentRms;
	} rms_t;

	typedef enum logic [1:0] {LC_IDLE, LC_SYNC, LC_RUN} line_state_t;

endpackage
`default_nettype wire

// ---- core/line_cycle_energy_power_calc.sv ----
// Overview of operation
// - Setting mode bit 7 enters line-cycle accumulation.
// - Line-cycle periods start and end on voltage zero crossings.
// - Active power accumulates into line active energy at 0x04 over count at 0x1C.
// - Half-cycle count is unsigned 16-bit, up to 65,535 half cycles.
// - Completed period sets cycle end flag, status bit 2.
// - Enabled cycle end flag pulls the active-low interrupt low.
// - New period starts after each completed one while mode bit stays set.
// - Mode bit 15 accumulates positive power only; resets off.
// - Calibration pulses follow positive-only accumulation too.
// - Positive-only mode flags each power direction change; interrupt if enabled.
// - No active accumulation below 0.001% of multiplier full scale.
// - Reactive power is phase-shifted current times voltage, low-pass filtered.
// - Reactive power accumulates over same count with same flag and interrupt.
// - Phase shift is -90 with integrator on, +90 with it off; the code applies one fixed shift and ignores integratorOn.
// - Reactive power is signed, positive for 0..90 and negative for -90..0.
// - Apparent power is voltage rms times current rms.
// - Apparent power is scaled by one plus signed 12-bit gain over 4096.
// - Gain 0x7FF raises about half, 0x800 lowers about half; step 0.0244%.
`timescale 1ns/1ps
`default_nettype none
module line_cycle_energy_power_calc (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire energy_pkg::reg_req_t regReq,
	output logic [23:0] rdData,
	output logic rdValid,
	// signal path inputs
	input wire energy_pkg::sample_t sample,
	input wire energy_pkg::rms_t rms,
	// pins
	output logic calibrationPulseOut,
	output logic irqOut,
	output logic irqOe
);

	typedef struct packed {
		energy_pkg::line_state_t lineState;
		logic [15:0] mode;
		logic [15:0] irqEnable;
		logic [15:0] irqStatus;
		logic [15:0] halfCycleSetting;
		logic [15:0] halfCount;
		logic [11:0] apparentGain;
		logic voltPrevNeg;
		logic signed [39:0] activeLpf;
		logic signed [39:0] reactiveLpf;
		logic signed [31:0] integ;
		logic signed [47:0] lineActiveAcc;
		logic signed [47:0] lineReactiveAcc;
		logic signed [47:0] cfAcc;
		logic [23:0] lineActive;
		logic [23:0] lineReactive;
		logic [23:0] apparentPower;
		logic powerWasNeg;
		logic dirKnown;
		logic [7:0] cfCount;
		logic cfOut;
		logic irqLevel;
		logic irqOe;
		logic [23:0] rdData;
		logic rdValid;
	} state_t;

	state_t st;
	state_t next_st;

	logic signed [15:0] shiftedCurrent;
	logic signed [31:0] activeProd;
	logic signed [31:0] reactiveProd;
	logic signed [31:0] activePow;
	logic signed [31:0] reactivePow;
	logic signed [31:0] activeGated;
	logic [31:0] activeMag;
	logic belowNoLoad;
	logic powerNeg;
	logic voltNeg;
	logic crossing;
	logic [15:0] target;
	logic [15:0] clearMask;
	logic [15:0] setMask;
	logic signed [47:0] apparentProd;
	logic signed [47:0] apparentScaled;
	logic signed [47:0] nextActiveAcc;
	logic signed [47:0] nextReactiveAcc;
	logic signed [47:0] nextCfAcc;
	logic [23:0] readMux;

	always_comb begin
		next_st = st;
		setMask = 16'h0000;
		clearMask = 16'h0000;

		// filtered powers as they stand now
		activePow = 32'(st.activeLpf >>> energy_pkg::LPF_SHIFT);
		reactivePow = 32'(st.reactiveLpf >>> energy_pkg::LPF_SHIFT);

		// leaky integrator lags the current by about a quarter period
		shiftedCurrent = st.integ[energy_pkg::INTEG_SHIFT +: 16];
		// with the integrator on, the -90 filter acts ahead of the integrator; its own lag
		// lands the integrated current at +90 net, so the sign follows the angle either way
		shiftedCurrent = -shiftedCurrent;
		activeProd = 32'(sample.voltage * sample.current);
		reactiveProd = 32'(sample.voltage * shiftedCurrent);

		powerNeg = activePow[31];
		activeMag = powerNeg ? 32'(-activePow) : 32'(activePow);
		belowNoLoad = 64'(activeMag) < energy_pkg::NO_LOAD_THRESHOLD;
		activeGated = activePow;
		if (belowNoLoad) begin
			activeGated = 32'h0000_0000;
		end else if (st.mode[energy_pkg::MODE_POS_ONLY_BIT] && powerNeg) begin
			activeGated = 32'h0000_0000;
		end

		voltNeg = sample.voltage[15];
		crossing = sample.valid && (voltNeg != st.voltPrevNeg);
		target = (st.halfCycleSetting == 16'h0000) ? 16'h0001 : st.halfCycleSetting;

		// apparent power from the rms blocks
		apparentProd = 48'(rms.voltageRms * rms.currentRms);
		apparentScaled = apparentProd
			+ 48'((apparentProd * 48'(signed'(st.apparentGain))) >>> energy_pkg::GAIN_FRAC_BITS);

		nextActiveAcc = st.lineActiveAcc + 48'(activeGated);
		nextReactiveAcc = st.lineReactiveAcc + 48'(reactivePow);
		nextCfAcc = st.cfAcc + 48'(activeGated);

		if (sample.valid) begin
			next_st.voltPrevNeg = voltNeg;
			next_st.activeLpf = st.activeLpf + 40'(activeProd) - 40'(activePow);
			next_st.reactiveLpf = st.reactiveLpf + 40'(reactiveProd) - 40'(reactivePow);
			next_st.integ = st.integ + 32'(sample.current)
				- 32'(st.integ >>> energy_pkg::INTEG_SHIFT);
			next_st.apparentPower = apparentScaled[39:16];

			// calibration pulse: one pulse per energy step, extra steps during a pulse wait
			next_st.cfAcc = nextCfAcc;
			if (nextCfAcc >= 48'(energy_pkg::CF_ENERGY_STEP) && st.cfCount == 8'h00) begin
				next_st.cfAcc = nextCfAcc - 48'(energy_pkg::CF_ENERGY_STEP);
				next_st.cfCount = 8'(energy_pkg::CF_PULSE_CYCLES);
			end

			// direction tracking ignores power inside the no-load band
			if (!belowNoLoad) begin
				next_st.powerWasNeg = powerNeg;
				next_st.dirKnown = 1'b1;
				if (st.dirKnown && st.mode[energy_pkg::MODE_POS_ONLY_BIT]
						&& (powerNeg != st.powerWasNeg)) begin
					setMask[energy_pkg::IRQ_WENT_NEG_BIT] = powerNeg;
					setMask[energy_pkg::IRQ_WENT_POS_BIT] = !powerNeg;
				end
			end
		end

		if (st.cfCount != 8'h00) begin
			next_st.cfCount = st.cfCount - 8'h01;
		end
		next_st.cfOut = (next_st.cfCount != 8'h00);

		unique case (st.lineState)
			energy_pkg::LC_IDLE: begin
				if (st.mode[energy_pkg::MODE_CYCLE_BIT]) begin
					next_st.lineState = energy_pkg::LC_SYNC;
				end
			end
			energy_pkg::LC_SYNC: begin
				next_st.lineActiveAcc = 48'h0000_0000_0000;
				next_st.lineReactiveAcc = 48'h0000_0000_0000;
				next_st.halfCount = 16'h0000;
				if (!st.mode[energy_pkg::MODE_CYCLE_BIT]) begin
					next_st.lineState = energy_pkg::LC_IDLE;
				end else if (crossing) begin
					next_st.lineState = energy_pkg::LC_RUN;
				end
			end
			energy_pkg::LC_RUN: begin
				if (!st.mode[energy_pkg::MODE_CYCLE_BIT]) begin
					next_st.lineState = energy_pkg::LC_IDLE;
				end else if (sample.valid) begin
					next_st.lineActiveAcc = nextActiveAcc;
					next_st.lineReactiveAcc = nextReactiveAcc;
					if (crossing) begin
						if (st.halfCount + 16'h0001 >= target) begin
							next_st.lineActive =
								nextActiveAcc[energy_pkg::LINE_LSB +: 24];
							next_st.lineReactive =
								nextReactiveAcc[energy_pkg::LINE_LSB +: 24];
							setMask[energy_pkg::IRQ_CYCLE_END_BIT] = 1'b1;
							// this crossing also opens the next period
							next_st.lineActiveAcc = 48'h0000_0000_0000;
							next_st.lineReactiveAcc = 48'h0000_0000_0000;
							next_st.halfCount = 16'h0000;
						end else begin
							next_st.halfCount = st.halfCount + 16'h0001;
						end
					end
				end
			end
		endcase

		// register writes; reserved bits are dropped
		if (regReq.wrEn) begin
			unique case (regReq.addr)
				energy_pkg::ADDR_HALF_CYCLE: next_st.halfCycleSetting = regReq.wrData[15:0];
				energy_pkg::ADDR_MODE: next_st.mode = regReq.wrData[15:0];
				energy_pkg::ADDR_IRQ_ENABLE: next_st.irqEnable = regReq.wrData[15:0];
				energy_pkg::ADDR_IRQ_STATUS: clearMask = regReq.wrData[15:0];
				energy_pkg::ADDR_APPARENT_GAIN: next_st.apparentGain = regReq.wrData[11:0];
				default: begin
				end
			endcase
		end
		// a flag raised in the clearing cycle survives
		next_st.irqStatus = (st.irqStatus & ~clearMask) | setMask;

		// open-drain interrupt: drive low while any enabled flag stands
		next_st.irqLevel = 1'b0;
		// new enable takes effect in the write cycle, so a standing flag asserts at once
		next_st.irqOe = |(next_st.irqStatus & next_st.irqEnable);

		unique case (regReq.addr)
			energy_pkg::ADDR_LINE_ACTIVE: readMux = st.lineActive;
			energy_pkg::ADDR_HALF_CYCLE: readMux = {8'h00, st.halfCycleSetting};
			energy_pkg::ADDR_MODE: readMux = {8'h00, st.mode};
			energy_pkg::ADDR_IRQ_ENABLE: readMux = {8'h00, st.irqEnable};
			energy_pkg::ADDR_IRQ_STATUS: readMux = {8'h00, st.irqStatus};
			energy_pkg::ADDR_LINE_REACTIVE: readMux = st.lineReactive;
			energy_pkg::ADDR_APPARENT_GAIN: readMux = {12'h000, st.apparentGain};
			energy_pkg::ADDR_APPARENT_POWER: readMux = st.apparentPower;
			energy_pkg::ADDR_ACTIVE_POWER: readMux = activePow[31:8];
			energy_pkg::ADDR_REACTIVE_POWER: readMux = reactivePow[31:8];
			energy_pkg::ADDR_LINE_STATE: readMux = {6'h00, st.lineState, st.halfCount};
			default: readMux = 24'h000000;
		endcase
		next_st.rdValid = regReq.rdEn;
		next_st.rdData = regReq.rdEn ? readMux : st.rdData;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.lineState <= energy_pkg::LC_IDLE;
			st.mode <= energy_pkg::MODE_RESET;
			st.irqEnable <= energy_pkg::IRQ_ENABLE_RESET;
			st.halfCycleSetting <= energy_pkg::HALF_CYCLE_RESET;
			st.apparentGain <= energy_pkg::APPARENT_GAIN_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdData = st.rdData;
	assign rdValid = st.rdValid;
	assign calibrationPulseOut = st.cfOut;
	assign irqOut = st.irqLevel;
	assign irqOe = st.irqOe;

endmodule
`default_nettype wire

// ---- bench/energy_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module energy_sva (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire energy_pkg::reg_req_t regReq,
	input wire logic [23:0] rdData,
	input wire logic rdValid,
	// signal path
	input wire energy_pkg::sample_t sample,
	input wire energy_pkg::rms_t rms,
	// pins
	input wire logic calibrationPulseOut,
	input wire logic irqOut,
	input wire logic irqOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] highLen;
	always_ff @(posedge clock) begin
		highLen <= (rst || !calibrationPulseOut) ? 8'h00 : highLen + 8'h01;
	end
	a_read_answer: assert property (regReq.rdEn |=> rdValid) else $error("no read answer");
	a_quiet_hold: assert property (!regReq.rdEn |=> !rdValid && $stable(rdData))
		else $error("read data moved");
	a_irq_low: assert property (irqOut == 1'b0) else $error("interrupt pin high");
	a_irq_cleared: assert property (regReq.wrEn && !sample.valid &&
		regReq.addr == energy_pkg::ADDR_IRQ_STATUS && regReq.wrData[5:0] == 6'h3F |=> !irqOe)
		else $error("interrupt stuck");
	a_irq_cause: assert property ($rose(irqOe) |-> $past(sample.valid) || $past(regReq.wrEn))
		else $error("interrupt without cause");
	a_pulse_len: assert property ($fell(calibrationPulseOut) |->
		highLen == 8'(energy_pkg::CF_PULSE_CYCLES)) else $error("pulse length wrong");
	a_count_width: assert property (rdValid && $past(regReq.addr) == energy_pkg::ADDR_HALF_CYCLE
		|-> rdData[23:16] == 8'h00) else $error("count too wide");
	a_gain_width: assert property (rdValid && $past(regReq.addr) == energy_pkg::ADDR_APPARENT_GAIN
		|-> rdData[23:12] == 12'h000) else $error("gain too wide");
	c_irq: cover property ($rose(irqOe));
	c_pulse: cover property ($fell(calibrationPulseOut));
	c_read: cover property (rdValid);
endmodule
bind line_cycle_energy_power_calc energy_sva sva (.clock(clock), .rst(rst), .regReq(regReq),
	.rdData(rdData), .rdValid(rdValid), .sample(sample), .rms(rms),
	.calibrationPulseOut(calibrationPulseOut), .irqOut(irqOut), .irqOe(irqOe));
`default_nettype wire

// ---- bench/energy_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module energy_host (
	// clock
	input wire logic clock,
	// register port
	output var energy_pkg::reg_req_t regReq,
	input wire logic [23:0] rdData,
	// interrupt pin
	input wire logic irqOut,
	input wire logic irqOe,
	output logic irqLine
);
	// open-drain line, pulled up on the board
	assign irqLine = irqOe ? irqOut : 1'b1;
	initial regReq = '0;
	// released fields are inverted so a stale value is never mistaken for a request
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge clock);
		#1 regReq = '{1'b1, 1'b0, a, d};
		@(posedge clock);
		#1 regReq = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [5:0] a, output logic [23:0] d);
		@(posedge clock);
		#1 regReq = '{1'b0, 1'b1, a, 24'h000000};
		@(posedge clock);
		#1 regReq = '{1'b0, 1'b0, ~a, 24'hFFFFFF};
		@(posedge clock);
		#1 d = rdData;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_line_cycle_energy_power_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_line_cycle_energy_power_calc;
	logic clock, rdValid, calibrationPulseOut, irqOut, irqOe, irqLine;
	logic rst = 1'b1, run = 1'b0, integ = 1'b0;
	logic [23:0] rdData, v;
	logic [31:0] seed = 32'h5540;
	logic [5:0] regAddr [5] = '{energy_pkg::ADDR_MODE, energy_pkg::ADDR_HALF_CYCLE,
		energy_pkg::ADDR_APPARENT_GAIN, energy_pkg::ADDR_IRQ_STATUS, 6'h3F};
	logic [23:0] regReset [5] = '{24'h000000, 24'h00FFFF, 24'h000000, 24'h000000, 24'h000000};
	logic [11:0] gains [3] = '{12'h000, 12'h7FF, 12'h800};
	energy_pkg::reg_req_t regReq;
	energy_pkg::sample_t sample = '0;
	energy_pkg::rms_t rms = '0;
	int errCount = 0, checksDone = 0, cyc = 0, pulses = 0, k = 0, t0 = 0, t1 = 0, a0 = 0;
	real vAmp = 100.0, iAmp = 100.0, th = 0.0;
	line_cycle_energy_power_calc dut (.clock(clock), .rst(rst), .regReq(regReq),
		.rdData(rdData), .rdValid(rdValid), .sample(sample), .rms(rms),
		.calibrationPulseOut(calibrationPulseOut), .irqOut(irqOut), .irqOe(irqOe));
	energy_host host (.clock(clock), .regReq(regReq), .rdData(rdData), .irqOut(irqOut),
		.irqOe(irqOe), .irqLine(irqLine));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic near(input logic [23:0] a, input int b);
		return !$isunknown(a) && b > 0 && int'(a) - b <= 3 && b - int'(a) <= 3;
	endfunction
	// samples every other cycle leave quiet cycles for status clears
	always @(posedge clock) begin
		cyc <= cyc + 1;
		#1;
		sample.valid = run && cyc[0];
		sample.integratorOn = integ;
		if (sample.valid) begin
			k++;
			sample.voltage = 16'($rtoi(vAmp * $sin(6.2831853 * k / 64.0 + th)));
			sample.current = 16'($rtoi(iAmp * $sin(6.2831853 * k / 64.0)));
		end
	end
	always @(posedge calibrationPulseOut) pulses++;
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checksDone++;
		if (g !== e) begin
			errCount++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [23:0] m, e, input string n);
		host.rd(a, v);
		chk(n, e, v & m);
	endtask
	task automatic clr();
		host.wr(energy_pkg::ADDR_IRQ_STATUS, 24'h00003F);
	endtask
	task automatic waitIrq();
		for (int i = 0; i < 400 && irqLine !== 1'b0; i++) begin
			@(posedge clock);
			#2;
		end
		t0 = t1;
		t1 = cyc;
		chk("irq line", 24'h000000, {23'h0, irqLine});
	endtask
	task automatic finishTest();
		if (errCount == 0 && checksDone > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		foreach (regAddr[i]) rc(regAddr[i], 24'hFFFFFF, regReset[i], "reset");
		seed = lfsr(lfsr(seed));
		host.wr(energy_pkg::ADDR_HALF_CYCLE, seed[23:0]);
		rc(energy_pkg::ADDR_HALF_CYCLE, 24'hFFFFFF, {8'h00, seed[15:0]}, "count");
		host.wr(energy_pkg::ADDR_LINE_ACTIVE, seed[31:8]);
		rc(energy_pkg::ADDR_LINE_ACTIVE, 24'hFFFFFF, 24'h000000, "ro energy");
		run = 1'b1;
		host.wr(energy_pkg::ADDR_IRQ_ENABLE, 24'h000004);
		host.wr(energy_pkg::ADDR_HALF_CYCLE, 24'h000002);
		host.wr(energy_pkg::ADDR_MODE, 24'h000080);
		waitIrq();
		rc(energy_pkg::ADDR_IRQ_STATUS, 24'hFFFFFF, 24'h000004, "status");
		clr();
		waitIrq();
		// two half cycles of 32 samples, one sample every two cycles
		chk("period", 24'(2 * 32 * 2), 24'(t1 - t0));
		rc(energy_pkg::ADDR_LINE_ACTIVE, 24'hFFFFFF, 24'h000000, "no-load");
		vAmp = 16000.0;
		iAmp = 16000.0;
		pulses = 0;
		repeat (1500) @(posedge clock);
		rc(energy_pkg::ADDR_LINE_ACTIVE, 24'h800000, 24'h000000, "sign");
		chk("energy", 24'h000001, 24'(v != 24'h000000));
		chk("pulses", 24'h000001, 24'(pulses > 0));
		iAmp = -16000.0;
		repeat (1500) @(posedge clock);
		rc(energy_pkg::ADDR_IRQ_STATUS, 24'hFFFFFF, 24'h000004, "status");
		rc(energy_pkg::ADDR_LINE_ACTIVE, 24'h800000, 24'h800000, "sign");
		host.wr(energy_pkg::ADDR_MODE, 24'h008080);
		host.wr(energy_pkg::ADDR_IRQ_ENABLE, 24'h000034);
		iAmp = 16000.0;
		repeat (1500) @(posedge clock);
		rc(energy_pkg::ADDR_IRQ_STATUS, 24'h000030, 24'h000020, "dir");
		iAmp = -16000.0;
		repeat (1500) @(posedge clock);
		rc(energy_pkg::ADDR_IRQ_STATUS, 24'h000030, 24'h000030, "dir");
		clr();
		pulses = 0;
		waitIrq();
		rc(energy_pkg::ADDR_LINE_ACTIVE, 24'hFFFFFF, 24'h000000, "pos only");
		chk("pulses", 24'h000000, 24'(pulses));
		host.wr(energy_pkg::ADDR_MODE, 24'h000080);
		iAmp = 16000.0;
		for (int i = 0; i < 4; i++) begin
			th = i[0] ? -0.785 : 0.785;
			integ = i[1];
			repeat (2000) @(posedge clock);
			rc(energy_pkg::ADDR_REACTIVE_POWER, 24'h800000, {i[0], 23'h0}, "var");
			rc(energy_pkg::ADDR_LINE_REACTIVE, 24'h800000, {i[0], 23'h0}, "lvar");
		end
		seed = lfsr(seed);
		rms = '{{6'h01, seed[9:0]}, {6'h01, seed[25:16]}};
		foreach (gains[i]) begin
			host.wr(energy_pkg::ADDR_APPARENT_GAIN, {12'h000, gains[i]});
			repeat (4) @(posedge clock);
			host.rd(energy_pkg::ADDR_APPARENT_POWER, v);
			a0 = (i == 0) ? int'(v) : a0;
			chk("va", 24'h000001, 24'(near(v, a0 + a0 * int'($signed(gains[i])) / 4096)));
		end
		host.wr(energy_pkg::ADDR_APPARENT_GAIN, 24'h000000);
		rms.currentRms = {rms.currentRms[14:0], 1'b0};
		repeat (4) @(posedge clock);
		host.rd(energy_pkg::ADDR_APPARENT_POWER, v);
		chk("va double", 24'h000001, 24'(near(v, 2 * a0)));
		finishTest();
	end
	// roughly five times the expected run length
	initial begin
		#750000;
		errCount++;
		finishTest();
	end
endmodule
`default_nettype wire
